// File: design/rx_irq_map.svh
`ifndef RX_IRQ_MAP_SVH
`define RX_IRQ_MAP_SVH
`define ALARM_IE_OFFSET 11'h12c
`define ERROR_IE_OFFSET 11'h12e
`define FE_COUNT_OFFSET 11'h134
`define ALARM_IE_RESET 16'h0000
`define ERROR_IE_RESET 16'h0000
`define FE_COUNT_RESET 16'h0000
`define ALARM_IE_MASK 16'h0fff
`define ERROR_IE_MASK 16'h0f0f
`define ERROR_EVENT_LSB 8
`define ERROR_COUNT_LSB 0
`endif

// File: design/rx_irq_pkg.sv
package rx_irq_pkg;
	typedef struct packed {
		logic [10:0] addr;
		logic [15:0] wdata;
		logic wr;
		logic rd;
	} cpu_req_t;
	typedef struct packed {
		logic cbit_parity;
		logic far_block;
		logic pbit_parity;
		logic framing;
	} err_evt_t;
	typedef enum logic [2:0] {
		CNT_IDLE = 3'b001,
		CNT_RUN = 3'b010,
		CNT_LOAD = 3'b100
	} cnt_state_t;
endpackage

// File: design/fe_tally.sv
`timescale 1ns/1ps
`default_nettype none
module fe_tally #(
	parameter int W = 16
) (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire logic event_in,
	input wire logic update_in,
	output logic [W-1:0] snapshot_out,
	output logic nonzero_out
);
	typedef struct packed {
		logic [W-1:0] acc;
		logic [W-1:0] snap;
	} tally_t;
	tally_t s_q, s_d;
	always_comb begin
		s_d = s_q;
		// Saturate rather than wrap so a long interval never reads small
		if (event_in && s_q.acc != {W{1'b1}})
			s_d.acc = s_q.acc + {{(W-1){1'b0}}, 1'b1};
		if (update_in) begin
			s_d.snap = s_q.acc;
			s_d.acc = {{(W-1){1'b0}}, event_in};
		end
	end
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in)
			s_q <= '0;
		else
			s_q <= s_d;
	end
	assign snapshot_out = s_q.snap;
	assign nonzero_out = (s_q.acc != '0);
endmodule
`default_nettype wire

// File: design/rx_irq_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "rx_irq_map.svh"
// Notes on behaviour
// - Interrupt needs latched bit, its enable and port global enable.
// - Enable bit zero disables its source, one enables it.
// - Alarm enable bits 10..0 gate the eleven alarm-change latches.
// - Error enable bits 11..8 gate the four error-event latches.
// - Error enable bits 3..0 gate the four count-nonzero latches.
// - Error enable register at 12Eh, resets zero, bits 15:12,7:4 unused.
// - Framing error count at 134h, read-only, 16 bits, resets zero.
// - Count register loads only on the performance-monitoring update.
// - Alarm-change latch sets on any change of its status bit.
// - Two-bit select chooses which framing error type counts.
// - In M23 mode C-bit and far-block latches stay zero.
module rx_irq_ctrl (
	input wire logic clk_in,
	input wire logic nrst_in,
	input wire rx_irq_pkg::cpu_req_t cpu_in,
	output logic [15:0] cpu_rdata_out,
	input wire logic port_status_irq_enable_in,
	input wire logic [10:0] alarm_status_in,
	input wire logic [3:0] framing_err_kind_in,
	input wire logic [1:0] framing_err_type_sel_in,
	input wire rx_irq_pkg::err_evt_t err_evt_in,
	input wire logic [3:0] count_nonzero_in,
	input wire logic m23_mode_in,
	input wire logic perf_mon_update_in,
	input wire logic [10:0] alarm_clear_in,
	input wire logic [3:0] event_clear_in,
	input wire logic [3:0] count_clear_in,
	output logic [10:0] alarm_latched_out,
	output logic [7:0] error_latched_out,
	output logic irq_out
);
	import rx_irq_pkg::*;
	// Address decode shared by the write path and the checks
	function automatic logic reg_hit(input cpu_req_t r, input logic [10:0] a);
		return r.addr == a;
	endfunction
	// One group of latches against its enables
	function automatic logic group_hit(input logic [10:0] lat, input logic [10:0] ie);
		return |(lat & ie);
	endfunction
	typedef struct packed {
		logic [15:0] alarm_ie;
		logic [15:0] error_ie;
		logic [10:0] alarm_prev;
		logic [10:0] alarm_lat;
		logic [3:0] evt_lat;
		logic [3:0] cnt_prev;
		logic [3:0] cnt_lat;
		logic [15:0] rdata;
	} state_t;
	state_t s_q, s_d;
	logic fe_event;
	logic fe_nonzero;
	logic [15:0] fe_snapshot;
	logic [3:0] evt_now;
	logic [3:0] cnt_now;
	logic [3:0] cnt_mask;
	assign fe_event = framing_err_kind_in[framing_err_type_sel_in];
	fe_tally #(.W(16)) u_tally (
		.clk_in(clk_in),
		.nrst_in(nrst_in),
		.event_in(fe_event),
		.update_in(perf_mon_update_in),
		.snapshot_out(fe_snapshot),
		.nonzero_out(fe_nonzero)
	);
	// M23 forces C-bit and far-block sources off
	assign cnt_mask = m23_mode_in ? 4'h3 : 4'hf;
	assign evt_now = {err_evt_in.cbit_parity, err_evt_in.far_block,
		err_evt_in.pbit_parity, fe_event} & cnt_mask;
	assign cnt_now = {count_nonzero_in[3:1], fe_nonzero} & cnt_mask;
	always_comb begin
		s_d = s_q;
		s_d.alarm_prev = alarm_status_in;
		s_d.cnt_prev = cnt_now;
		// change in either direction sets, set beats clear
		s_d.alarm_lat = (s_q.alarm_lat & ~alarm_clear_in) | (alarm_status_in ^ s_q.alarm_prev);
		s_d.evt_lat = ((s_q.evt_lat & ~event_clear_in) | evt_now) & cnt_mask;
		s_d.cnt_lat = ((s_q.cnt_lat & ~count_clear_in) | (cnt_now & ~s_q.cnt_prev)) & cnt_mask;
		// writable bits only, unused bits stay zero
		if (cpu_in.wr && reg_hit(cpu_in, `ALARM_IE_OFFSET))
			s_d.alarm_ie = cpu_in.wdata & `ALARM_IE_MASK;
		if (cpu_in.wr && reg_hit(cpu_in, `ERROR_IE_OFFSET))
			s_d.error_ie = cpu_in.wdata & `ERROR_IE_MASK;
		s_d.rdata = 16'h0000;
		if (cpu_in.rd) begin
			case (cpu_in.addr)
				`ALARM_IE_OFFSET: s_d.rdata = s_q.alarm_ie;
				`ERROR_IE_OFFSET: s_d.rdata = s_q.error_ie;
				`FE_COUNT_OFFSET: s_d.rdata = fe_snapshot;
				default: s_d.rdata = 16'h0000;
			endcase
		end
	end
	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			s_q <= '0;
			s_q.alarm_ie <= `ALARM_IE_RESET;
			s_q.error_ie <= `ERROR_IE_RESET;
		end else begin
			s_q <= s_d;
		end
	end
	logic [7:0] err_lat;
	logic alarm_hit;
	logic event_hit;
	logic count_hit;
	logic any_src;
	assign err_lat = {s_q.evt_lat, s_q.cnt_lat};
	// alarm gating bits 10..0
	// Alarm enable bit 11 has no latch behind it, so it gates nothing
	assign alarm_hit = group_hit(s_q.alarm_lat, s_q.alarm_ie[10:0]);
	assign event_hit = group_hit({7'h00, s_q.evt_lat},
		{7'h00, s_q.error_ie[`ERROR_EVENT_LSB +: 4]});
	assign count_hit = group_hit({7'h00, s_q.cnt_lat},
		{7'h00, s_q.error_ie[`ERROR_COUNT_LSB +: 4]});
	assign any_src = alarm_hit | event_hit | count_hit;
	assign irq_out = any_src & port_status_irq_enable_in;
	assign cpu_rdata_out = s_q.rdata;
	assign alarm_latched_out = s_q.alarm_lat;
	assign error_latched_out = err_lat;

	a_irq_gating: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(irq_out |-> port_status_irq_enable_in))
		else $error("irq without port enable");
	a_irq_off_disabled: assert property (@(posedge clk_in) disable iff (!nrst_in)
		((s_q.alarm_ie == 16'h0000 && s_q.error_ie == 16'h0000) |-> !irq_out))
		else $error("irq with all enables off");
	a_alarm_src: assert property (@(posedge clk_in) disable iff (!nrst_in)
		((port_status_irq_enable_in && |(s_q.alarm_lat & s_q.alarm_ie[10:0])) |-> irq_out))
		else $error("enabled alarm latch gave no irq");
	a_event_src: assert property (@(posedge clk_in) disable iff (!nrst_in)
		((port_status_irq_enable_in && |(s_q.evt_lat & s_q.error_ie[11:8])) |-> irq_out))
		else $error("enabled event latch gave no irq");
	a_count_src: assert property (@(posedge clk_in) disable iff (!nrst_in)
		((port_status_irq_enable_in && |(s_q.cnt_lat & s_q.error_ie[3:0])) |-> irq_out))
		else $error("enabled count latch gave no irq");
	a_unused_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
		((s_q.error_ie & 16'hf0f0) == 16'h0000))
		else $error("unused enable bits set");
	a_count_hold: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(!$past(perf_mon_update_in) |-> $stable(fe_snapshot)))
		else $error("count changed without update");
	a_count_load: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(perf_mon_update_in |=> fe_snapshot != 16'h0000 || $past(!fe_nonzero)))
		else $error("count not loaded");
	a_alarm_change: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(alarm_status_in != $past(alarm_status_in) |=>
			(s_q.alarm_lat & $past(alarm_status_in ^ $past(alarm_status_in))) ==
			$past(alarm_status_in ^ $past(alarm_status_in))))
		else $error("alarm change not latched");
	a_m23_zero: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(m23_mode_in |=> (s_q.evt_lat[3:2] == 2'b00 && s_q.cnt_lat[3:2] == 2'b00)))
		else $error("m23 latches not zero");
	a_irq_drop: assert property (@(posedge clk_in) disable iff (!nrst_in)
		((s_q.alarm_lat == '0 && s_q.evt_lat == '0 && s_q.cnt_lat == '0) |-> !irq_out))
		else $error("irq with no latch");
	c_alarm_irq: cover property (@(posedge clk_in) disable iff (!nrst_in)
		|(s_q.alarm_lat & s_q.alarm_ie[10:0]) && irq_out);
	c_event_irq: cover property (@(posedge clk_in) disable iff (!nrst_in)
		|(s_q.evt_lat & s_q.error_ie[11:8]) && irq_out);
	c_count_load: cover property (@(posedge clk_in) disable iff (!nrst_in)
		perf_mon_update_in ##1 fe_snapshot != 16'h0000);
	c_m23_count: cover property (@(posedge clk_in) disable iff (!nrst_in)
		m23_mode_in && s_q.cnt_lat[1]);
	c_alarm_clear: cover property (@(posedge clk_in) disable iff (!nrst_in)
		|s_q.alarm_lat ##1 s_q.alarm_lat == 11'h000);

	// Latch checks
	// event latch follows pulse
	a_event_latch: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(evt_now[1] |=> s_q.evt_lat[1]))
		else $error("pbit event not latched");
	a_frame_latch: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(fe_event |=> s_q.evt_lat[0]))
		else $error("framing event not latched");
	a_count_rise: assert property (@(posedge clk_in) disable iff (!nrst_in)
		((cnt_now & ~s_q.cnt_prev) != 4'h0 |=>
			(s_q.cnt_lat & $past(cnt_now & ~s_q.cnt_prev)) == $past(cnt_now & ~s_q.cnt_prev)))
		else $error("count rise not latched");
	// full alarm clear with no change empties alarm latches
	a_alarm_clear: assert property (@(posedge clk_in) disable iff (!nrst_in)
		((alarm_clear_in == 11'h7ff && alarm_status_in == s_q.alarm_prev) |=>
			s_q.alarm_lat == 11'h000))
		else $error("alarm latch not cleared");

	// Register map checks
	// alarm enable upper bits unused
	a_alarm_ie_mask: assert property (@(posedge clk_in) disable iff (!nrst_in)
		((s_q.alarm_ie & 16'hf000) == 16'h0000))
		else $error("alarm enable unused bits set");
	a_ie_write: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(cpu_in.wr && reg_hit(cpu_in, `ERROR_IE_OFFSET) |=>
			s_q.error_ie == ($past(cpu_in.wdata) & `ERROR_IE_MASK)))
		else $error("error enable write lost");
	a_ie_read: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(cpu_in.rd && cpu_in.addr == `ERROR_IE_OFFSET |=>
			cpu_rdata_out == $past(s_q.error_ie)))
		else $error("error enable read wrong");
	a_rdata_idle: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(!$past(cpu_in.rd) |-> cpu_rdata_out == 16'h0000))
		else $error("read data without read");
	a_count_ro: assert property (@(posedge clk_in) disable iff (!nrst_in)
		(cpu_in.wr && cpu_in.addr == `FE_COUNT_OFFSET && !perf_mon_update_in |=>
			$stable(fe_snapshot)))
		else $error("count changed by write");
endmodule
`default_nettype wire

// File: test/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
	import rx_irq_pkg::*;
	typedef struct packed {logic [15:0] ie; logic [10:0] tg; logic pe; logic irq;} row_t;
	logic clk_in = 0;
	logic nrst_in = 0;
	cpu_req_t cpu = '0;
	logic pe = 0, m23 = 0, perf_mon_update = 0, irq;
	logic [15:0] rdata;
	logic [10:0] ast = '0, aclr = '0, alat;
	logic [3:0] fk = '0, ecl = '0, ccl = '0, cnz = '0;
	logic [1:0] fsel = '0;
	logic [7:0] elat;
	err_evt_t ev = '0;
	int failures = 0, num_checks = 0, cycles = 0;
	// Toggle masks per enable pattern; row with port enable off must stay quiet
	row_t rows [6] = '{'{16'h0001, 11'h001, 1, 1}, '{16'h0400, 11'h400, 1, 1},
		'{16'h0400, 11'h001, 1, 0}, '{16'h07ff, 11'h020, 0, 0},
		'{16'h0000, 11'h7ff, 1, 0}, '{16'h0080, 11'h080, 1, 1}};
	rx_irq_ctrl u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .cpu_in(cpu), .cpu_rdata_out(rdata),
		.port_status_irq_enable_in(pe), .alarm_status_in(ast), .framing_err_kind_in(fk),
		.framing_err_type_sel_in(fsel), .err_evt_in(ev), .count_nonzero_in(cnz),
		.m23_mode_in(m23), .perf_mon_update_in(perf_mon_update), .alarm_clear_in(aclr),
		.event_clear_in(ecl), .count_clear_in(ccl), .alarm_latched_out(alat),
		.error_latched_out(elat), .irq_out(irq));
	initial begin
		forever #2 clk_in = ~clk_in;
	end
	task automatic results();
		if (failures == 0 && num_checks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	// Hang guard, generous against roughly 90 cycles of tests
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			failures++;
			results();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		num_checks++;
		if (got !== exp) begin
			failures++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [10:0] a, input logic [15:0] d);
		@(negedge clk_in) cpu = '{a, d, 1'b1, 1'b0};
		@(negedge clk_in) cpu.wr = 0;
	endtask
	// Read data stands from the taking edge and is checked at the next falling edge
	task automatic rdc(input logic [10:0] a, input logic [15:0] e);
		@(negedge clk_in) cpu = '{a, 16'h0, 1'b0, 1'b1};
		@(negedge clk_in) cpu.rd = 0;
		chk(rdata, e);
	endtask
	task automatic pulse_evt(input err_evt_t e);
		@(negedge clk_in) ev = e;
		@(negedge clk_in) ev = '0;
	endtask
	task automatic clr();
		@(negedge clk_in) {aclr, ecl, ccl} = '1;
		@(negedge clk_in) {aclr, ecl, ccl} = '0;
	endtask
	initial begin
		repeat (8) @(negedge clk_in);
		nrst_in = 1;
		rdc(11'h12c, 16'h0);
		rdc(11'h12e, 16'h0);
		rdc(11'h134, 16'h0);
		chk({15'h0, irq}, 16'h0);
		foreach (rows[i]) begin
			wr(11'h12c, rows[i].ie);
			pe = rows[i].pe;
			ast = ast ^ rows[i].tg;
			@(negedge clk_in);
			chk({5'h0, alat}, {5'h0, rows[i].tg});
			chk({15'h0, irq}, {15'h0, rows[i].irq});
			clr();
			chk({15'h0, irq}, 16'h0);
		end
		wr(11'h12e, 16'hffff);
		rdc(11'h12e, 16'h0f0f);
		wr(11'h134, 16'h1234);
		rdc(11'h134, 16'h0);
		rdc(11'h130, 16'h0);
		pe = 1;
		pulse_evt(4'b0010);
		chk({8'h0, elat}, 16'h0020);
		chk({15'h0, irq}, 16'h1);
		clr();
		// M23 keeps C-bit and far-block latches clear though their inputs fire
		m23 = 1;
		cnz = 4'b1110;
		pulse_evt(4'b1100);
		chk({8'h0, elat}, 16'h0002);
		chk({15'h0, irq}, 16'h1);
		m23 = 0;
		cnz = 0;
		clr();
		wr(11'h12e, 16'h0);
		pulse_evt(4'b0010);
		chk({15'h0, irq}, 16'h0);
		clr();
		fsel = 2'b01;
		for (int i = 0; i < 4; i++) begin
			@(negedge clk_in) fk = (i == 3) ? 4'b0001 : 4'b0010;
			@(negedge clk_in) fk = 0;
		end
		chk({8'h0, elat}, 16'h0011);
		rdc(11'h134, 16'h0);
		@(negedge clk_in) perf_mon_update = 1;
		@(negedge clk_in) perf_mon_update = 0;
		rdc(11'h134, 16'h3);
		@(negedge clk_in) perf_mon_update = 1;
		@(negedge clk_in) perf_mon_update = 0;
		rdc(11'h134, 16'h0);
		wr(11'h12e, 16'h0101);
		nrst_in = 0;
		@(negedge clk_in) nrst_in = 1;
		rdc(11'h12e, 16'h0);
		results();
	end
endmodule
`default_nettype wire
